// [logic/dffpc_ctrl.sv]
// Loop-zero control bank: frequency-fail masks, reference sampling, build-out control.
// Assumes the configuration port, monitors and phase detector share clk.
`include "dffpc_map.svh"
`default_nettype none
module dffpc_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration port
  input wire logic [`DFFPC_ADDR_W-1:0] cfg_addr,
  input wire logic cfg_wr,
  input wire dffpc_pkg::dffpc_byte_t cfg_wdata,
  input wire logic cfg_rd,
  output dffpc_pkg::dffpc_byte_t cfg_rdata,
  // Reference monitor and reference
  input wire logic ref_freq_fail,
  input wire logic ref_in,
  // Phase detector and build-out thresholds
  input wire logic phase_valid,
  input wire logic [7:0] phase_err,
  input wire logic [7:0] phase_slope,
  input wire logic [7:0] phase_err_th,
  input wire logic [7:0] slope_th,
  // Loop steering
  output logic ref_switch_req,
  output logic holdover_req,
  output dffpc_pkg::dffpc_mode_e ref_sample_mode,
  output logic ref_sample,
  output logic [`DFFPC_DELAY_W-1:0] holdover_store_delay_ms,
  // Build-out results
  output logic pbo_fire,
  output logic [`DFFPC_CNT_W-1:0] pbo_count,
  output logic [`DFFPC_ACC_W-1:0] pbo_phase_acc
);
  import dffpc_pkg::*;

  dffpc_byte_t ffm_r, ffm_nxt;
  dffpc_byte_t ehd_r, ehd_nxt;
  dffpc_byte_t pac_r, pac_nxt;
  dffpc_byte_t rdata_r, rdata_nxt;

  function automatic dffpc_byte_t read_mux(input logic [`DFFPC_ADDR_W-1:0] a,
                                           input dffpc_byte_t f, input dffpc_byte_t e,
                                           input dffpc_byte_t p);
    unique case (a)
      `DFFPC_ADDR_FFM: read_mux = f;
      `DFFPC_ADDR_EHD: read_mux = e;
      `DFFPC_ADDR_PAC: read_mux = p;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Register file
  always_comb begin
    ffm_nxt = ffm_r;
    ehd_nxt = ehd_r;
    pac_nxt = pac_r;
    rdata_nxt = rdata_r;
    if (cfg_wr) begin
      if (cfg_addr == `DFFPC_ADDR_FFM) begin
        ffm_nxt = (cfg_wdata & `DFFPC_FFM_MASK) | (`DFFPC_RST_FFM & ~`DFFPC_FFM_MASK);
      end
      if (cfg_addr == `DFFPC_ADDR_EHD) begin
        ehd_nxt = (cfg_wdata & `DFFPC_EHD_MASK) | (`DFFPC_RST_EHD & ~`DFFPC_EHD_MASK);
      end
      if (cfg_addr == `DFFPC_ADDR_PAC) begin
        pac_nxt = (cfg_wdata & `DFFPC_PAC_MASK) | (`DFFPC_RST_PAC & ~`DFFPC_PAC_MASK);
      end
    end
    if (cfg_rd) begin
      rdata_nxt = read_mux(cfg_addr, ffm_r, ehd_r, pac_r);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ffm_r <= `DFFPC_RST_FFM;
      ehd_r <= `DFFPC_RST_EHD;
      pac_r <= `DFFPC_RST_PAC;
      rdata_r <= 8'h00;
    end else begin
      ffm_r <= ffm_nxt;
      ehd_r <= ehd_nxt;
      pac_r <= pac_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign cfg_rdata = rdata_r;

  // Failure steering
  logic switch_r, switch_nxt, hold_r, hold_nxt;
  always_comb begin
    switch_nxt = ref_freq_fail & ffm_r[`DFFPC_BIT_SWITCH];
    hold_nxt = ref_freq_fail & ffm_r[`DFFPC_BIT_HOLD];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      switch_r <= switch_nxt;
      hold_r <= hold_nxt;
    end
  end
  assign ref_switch_req = switch_r;
  assign holdover_req = hold_r;

  // Reference sampling
  dffpc_mode_e mode_r, mode_nxt;
  logic prev_r, prev_nxt, samp_r, samp_nxt;
  logic [`DFFPC_RUN_W-1:0] run_r, run_nxt, width_r, width_nxt;
  logic in_pulse;

  always_comb begin
    mode_nxt = dffpc_mode_e'(ehd_r[`DFFPC_MODE_HI:`DFFPC_MODE_LO]);
    prev_nxt = ref_in;
    in_pulse = (mode_r == DFFPC_HIGH_PULSE) ? ref_in : ~ref_in;
    width_nxt = width_r;
    if (ref_in != prev_r) begin
      run_nxt = '0;
      // Last pulse width predicts where the middle of the next one lies
      if (in_pulse == 1'b0) begin
        width_nxt = run_r;
      end
    end else if (run_r != `DFFPC_RUN_MAX) begin
      run_nxt = run_r + 16'h0001;
    end else begin
      run_nxt = run_r;
    end
    unique case (mode_r)
      DFFPC_RISE: samp_nxt = ref_in & ~prev_r;
      DFFPC_FALL: samp_nxt = ~ref_in & prev_r;
      DFFPC_LOW_PULSE, DFFPC_HIGH_PULSE: begin
        samp_nxt = in_pulse & (run_nxt == {1'b0, width_r[`DFFPC_RUN_W-1:1]});
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= DFFPC_RISE;
      prev_r <= 1'b0;
      samp_r <= 1'b0;
      run_r <= '0;
      width_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      prev_r <= prev_nxt;
      samp_r <= samp_nxt;
      run_r <= run_nxt;
      width_r <= width_nxt;
    end
  end
  assign ref_sample_mode = mode_r;
  assign ref_sample = samp_r;

  // Holdover storage delay
  dffpc_delay_rom u_delay_rom (
    .clk(clk),
    .rst_n(rst_n),
    .code(ehd_r[`DFFPC_CODE_HI:0]),
    .delay_ms(holdover_store_delay_ms)
  );

  // Phase build-out
  logic fire_r, fire_nxt;
  logic [`DFFPC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`DFFPC_ACC_W-1:0] acc_r, acc_nxt;

  always_comb begin
    fire_nxt = pac_r[`DFFPC_BIT_PBO] & phase_valid &
               (phase_err > phase_err_th) & (phase_slope > slope_th);
    if (!pac_r[`DFFPC_BIT_CNT]) begin
      cnt_nxt = '0;
    end else if (fire_r) begin
      cnt_nxt = cnt_r + 16'h0001;
    end else begin
      cnt_nxt = cnt_r;
    end
    if (!pac_r[`DFFPC_BIT_ACC]) begin
      acc_nxt = '0;
    end else if (fire_r) begin
      acc_nxt = acc_r + {12'h000, phase_err};
    end else begin
      acc_nxt = acc_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fire_r <= 1'b0;
      cnt_r <= '0;
      acc_r <= '0;
    end else begin
      fire_r <= fire_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
    end
  end
  assign pbo_fire = fire_r;
  assign pbo_count = cnt_r;
  assign pbo_phase_acc = acc_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_switch_mask_gate: assert property (
    switch_r |-> $past(ref_freq_fail) && $past(ffm_r[`DFFPC_BIT_SWITCH]))
    else $error("switch request without enabled failure");
  chk_hold_mask_gate: assert property (
    ref_freq_fail && ffm_r[`DFFPC_BIT_HOLD] |=> hold_r)
    else $error("holdover request missed");
  chk_mode_follows_reg: assert property (
    ##1 $stable(ehd_r) |-> mode_r == dffpc_mode_e'($past(ehd_r[7:6])))
    else $error("sample mode does not follow register");
  chk_rise_sample: assert property (
    mode_r == DFFPC_RISE && ref_in && !prev_r |=> samp_r)
    else $error("rising edge not sampled");
  chk_pulse_no_edge: assert property (
    (mode_r == DFFPC_HIGH_PULSE) && ref_in && !prev_r && width_r > 16'h0003 |=> !samp_r)
    else $error("pulse mode sampled on edge");
  chk_delay_default: assert property (
    $rose(rst_n) |-> ehd_r[4:0] == 5'h0B)
    else $error("delay code default wrong");
  chk_delay_map: assert property (
    ehd_r[4:0] == 5'h10 ##1 ehd_r[4:0] == 5'h10 |=> holdover_store_delay_ms == 17'h003E8)
    else $error("one second code mismatch");
  chk_acc_clear: assert property (
    !pac_r[`DFFPC_BIT_ACC] |=> acc_r == '0)
    else $error("accumulator not held at zero");
  chk_cnt_step: assert property (
    pac_r[`DFFPC_BIT_CNT] && fire_r |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("occurrence not counted");
  chk_pbo_disabled: assert property (
    !pac_r[`DFFPC_BIT_PBO] |=> !fire_r)
    else $error("build-out while disabled");
  chk_pbo_thresh: assert property (
    fire_r |-> $past(phase_err) > $past(phase_err_th) && $past(phase_slope) > $past(slope_th))
    else $error("build-out below threshold");
  chk_reserved_zero: assert property (
    (pac_r & ~`DFFPC_PAC_MASK) == 8'h00 && (ffm_r & ~`DFFPC_FFM_MASK) == 8'h00)
    else $error("reserved bits changed");
endmodule // dffpc_ctrl
`default_nettype wire

// [logic/dffpc_map.svh]
// Constants of the loop-zero frequency-fail, sampling and build-out control bank.
// Assumes an 8-bit configuration port with 9-bit addresses.
// What this block does
// - Frequency failure causes reference switch only when mask bit 4 is set.
// - Frequency failure causes holdover only when mask bit 0 is set.
// - Bits 7:6 pick rising, falling, low-pulse or high-pulse reference sampling.
// - Pulse modes sample midway between the two edges of the pulse.
// - Delay code in bits 4:0 maps to ten ms times ten to code/8.
// - Delay code resets to eleven, about 237 ms.
// - Build-out control bit 2 enables phase accumulation; low holds it at zero.
// - Build-out control bit 1 enables occurrence counting; low holds it at zero.
// - Build-out control bit 0 enables build-out; reset leaves it disabled.
// - Build-out fires only when phase error and slope exceed their thresholds.
`ifndef DFFPC_MAP_SVH
`define DFFPC_MAP_SVH

`define DFFPC_ADDR_W 9
`define DFFPC_ADDR_FFM 9'h10E
`define DFFPC_ADDR_EHD 9'h10F
`define DFFPC_ADDR_PAC 9'h110

`define DFFPC_RST_FFM 8'h01
`define DFFPC_RST_EHD 8'h0B
`define DFFPC_RST_PAC 8'h00
`define DFFPC_RST_DELAY 17'h000ED

`define DFFPC_FFM_MASK 8'h11
`define DFFPC_EHD_MASK 8'hDF
`define DFFPC_PAC_MASK 8'h07

`define DFFPC_BIT_SWITCH 4
`define DFFPC_BIT_HOLD 0
`define DFFPC_MODE_HI 7
`define DFFPC_MODE_LO 6
`define DFFPC_CODE_HI 4
`define DFFPC_BIT_ACC 2
`define DFFPC_BIT_CNT 1
`define DFFPC_BIT_PBO 0

`define DFFPC_RUN_W 16
`define DFFPC_RUN_MAX 16'hFFFF
`define DFFPC_DELAY_W 17
`define DFFPC_ACC_W 20
`define DFFPC_CNT_W 16

`endif

// [logic/dffpc_pkg.sv]
// Types shared by the control bank and its delay table.
// Assumes the map header supplies all numeric constants.
`default_nettype none
package dffpc_pkg;
  typedef enum logic [1:0] {
    DFFPC_RISE,
    DFFPC_FALL,
    DFFPC_LOW_PULSE,
    DFFPC_HIGH_PULSE
  } dffpc_mode_e;
  typedef logic [7:0] dffpc_byte_t;
endpackage
`default_nettype wire

// [logic/dffpc_delay_rom.sv]
// Holdover storage delay table: five-bit code to delay in milliseconds.
// Assumes one clock; data appear one cycle after the code.
`include "dffpc_map.svh"
`default_nettype none
module dffpc_delay_rom (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Lookup
  input wire logic [4:0] code,
  output logic [`DFFPC_DELAY_W-1:0] delay_ms
);
  import dffpc_pkg::*;

  // Each step is an eighth of a decade, rounded from 10 ms * 10^(code/8)
  localparam logic [`DFFPC_DELAY_W-1:0] TABLE [32] = '{
    17'h0000A, 17'h0000D, 17'h00012, 17'h00018, 17'h00020, 17'h0002A, 17'h00038, 17'h0004B,
    17'h00064, 17'h00085, 17'h000B2, 17'h000ED, 17'h0013C, 17'h001A6, 17'h00232, 17'h002EE,
    17'h003E8, 17'h00536, 17'h006F2, 17'h00943, 17'h00C5A, 17'h01079, 17'h015F7, 17'h01D4B,
    17'h02710, 17'h03417, 17'h04577, 17'h05CA2, 17'h07B87, 17'h0A4BA, 17'h0DBAA, 17'h124ED
  };

  logic [`DFFPC_DELAY_W-1:0] delay_nxt;

  always_comb begin
    delay_nxt = TABLE[code];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Matches the reset code so the output is consistent before the first lookup
      delay_ms <= `DFFPC_RST_DELAY;
    end else begin
      delay_ms <= delay_nxt;
    end
  end
endmodule // dffpc_delay_rom
`default_nettype wire

// [verif/dffpc_ref_model.sv]
// Selected reference model: a pulse train of programmable high and low widths.
// Assumes widths of at least four cycles; levels change just after a rising edge.
`default_nettype none
module dffpc_ref_model (
  // Clock
  input wire logic clk,
  // Widths in cycles
  input wire logic [3:0] hi_w,
  input wire logic [3:0] lo_w,
  // Reference
  output logic ref_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] run_r = 4'h0;
  initial ref_in = 1'b0;
  always @(posedge clk) begin
    if (run_r + 4'h1 >= (ref_in ? hi_w : lo_w)) begin
      ref_in <= !ref_in;
      run_r <= 4'h0;
    end else begin
      run_r <= run_r + 4'h1;
    end
  end
endmodule // dffpc_ref_model
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench of the loop-zero control bank.
// Assumes the map header, package and design files are compiled first.
`include "dffpc_map.svh"
`default_nettype none
module testbench import dffpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, fail = 1'b0, pv = 1'b0;
  logic [8:0] addr = 9'h000;
  dffpc_byte_t wdata = 8'h00, rdata;
  logic [7:0] err = 8'h00, slope = 8'h00, eth = 8'h00, sth = 8'h00, t, u, e;
  logic sw, ho, smp, fire, ref_in, hit, sm_on = 1'b0, rd_pend = 1'b0;
  logic [1:0] emode;
  dffpc_mode_e mode;
  logic [`DFFPC_DELAY_W-1:0] dly;
  logic [`DFFPC_CNT_W-1:0] cnt, ecnt;
  logic [`DFFPC_ACC_W-1:0] acc, eacc;
  logic [4:0] dc[5] = '{5'h00, 5'h08, 5'h10, 5'h18, 5'h1F};
  logic [16:0] dv[5] = '{17'h0000A, 17'h00064, 17'h003E8, 17'h02710, 17'h124ED};
  dffpc_byte_t rq[$];
  int n_fail = 0, cmp_count = 0, cyc = 0, nsmp = 0;
  always #2 clk = !clk;
  dffpc_ctrl dut_u (.clk(clk), .rst_n(rst_n), .cfg_addr(addr), .cfg_wr(wr), .cfg_wdata(wdata),
    .cfg_rd(rd), .cfg_rdata(rdata), .ref_freq_fail(fail), .ref_in(ref_in), .phase_valid(pv),
    .phase_err(err), .phase_slope(slope), .phase_err_th(eth), .slope_th(sth),
    .ref_switch_req(sw), .holdover_req(ho), .ref_sample_mode(mode), .ref_sample(smp),
    .holdover_store_delay_ms(dly), .pbo_fire(fire), .pbo_count(cnt), .pbo_phase_acc(acc));
  dffpc_ref_model ref_u (.clk(clk), .hi_w(4'hA), .lo_w(4'h8), .ref_in(ref_in));
  task automatic chk(string nm, logic [19:0] ex, logic [19:0] got);
    cmp_count++;
    if (ex !== got) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wreg(logic [8:0] a, dffpc_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [8:0] a, dffpc_byte_t ex);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rq.push_back(ex);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Read data settles one cycle after the strobe
  always @(posedge clk) rd_pend <= rd;
  always @(negedge clk) begin
    if (rd_pend) begin
      chk("cfg_rdata", rq.pop_front(), rdata);
    end
  end
  // Pre-edge values: the sample point must fall inside the chosen level
  always @(posedge clk) begin
    if (sm_on && smp) begin
      nsmp++;
      chk("sample level", emode == 2'h0 || emode == 2'h3, ref_in);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'h1CA3AA82));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk("delay reset", 17'h000ED, dly);
    rreg(9'h10E, 8'h01);
    rreg(9'h10F, 8'h0B);
    rreg(9'h110, 8'h00);
    rreg(9'h111, 8'h00);
    wreg(9'h10E, 8'hFF);
    rreg(9'h10E, 8'h11);
    wreg(9'h10F, 8'hFF);
    rreg(9'h10F, 8'hDF);
    wreg(9'h110, 8'hFF);
    rreg(9'h110, 8'h07);
    wreg(9'h110, 8'h00);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wreg(9'h10E, {3'h0, m[1], 3'h0, m[0]});
      fail <= 1'b1;
      tick(3);
      chk("switch", m[1], sw);
      chk("holdover", m[0], ho);
      @(posedge clk);
      fail <= 1'b0;
      tick(2);
      chk("switch idle", 1'b0, sw);
      chk("holdover idle", 1'b0, ho);
    end
    $display("test masks done");
    foreach (dc[i]) begin
      wreg(9'h10F, {3'h0, dc[i]});
      tick(4);
      chk("delay", dv[i], dly);
    end
    $display("test delay done");
    for (int m = 0; m < 4; m++) begin
      emode = m[1:0];
      wreg(9'h10F, {emode, 6'h0B});
      tick(40);
      chk("mode", emode, mode);
      nsmp = 0;
      sm_on = 1'b1;
      tick(180);
      sm_on = 1'b0;
      chk("samples", 1'b1, nsmp > 8 && nsmp < 12);
    end
    $display("test sampling done");
    wreg(9'h110, 8'h07);
    ecnt = '0;
    eacc = '0;
    for (int i = 0; i < 15; i++) begin
      t = 8'($urandom_range(127));
      u = 8'($urandom_range(127));
      hit = (i % 3) != 0;
      e = hit ? t + 8'h01 + 8'($urandom_range(126)) : t;
      @(posedge clk);
      eth <= t;
      sth <= u;
      err <= e;
      slope <= u + 8'h01;
      pv <= 1'b1;
      @(posedge clk);
      pv <= 1'b0;
      tick(0);
      chk("fire", hit, fire);
      ecnt += 16'(hit);
      eacc += hit ? 20'(e) : 20'h00000;
    end
    tick(2);
    chk("count", ecnt, cnt);
    chk("phase sum", eacc, acc);
    wreg(9'h110, 8'h06);
    pv <= 1'b1;
    err <= 8'hFF;
    @(posedge clk);
    pv <= 1'b0;
    tick(0);
    chk("fire off", 1'b0, fire);
    wreg(9'h110, 8'h01);
    tick(3);
    chk("count clear", 16'h0000, cnt);
    chk("sum clear", 20'h00000, acc);
    $display("test build-out done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
